//--- verilog/csr_setpoint_bank.sv
// charger setpoint register bank behind a serial two-wire slave
// Notes on behaviour
// - reverse current low byte holds reserved bits only
// - input regulation code spans two bytes, 64-8192 mV
// - input regulation covers 3200 to 19520 mV
// - input regulation adds fixed 3.2 V offset
// - out-of-range input regulation write is ignored
// - minimum system code in upper bits 5..0
// - minimum system spans 1024 to 16128 mV
// - actual minimum system is 160 mV higher
// - out-of-range minimum system write is ignored
// - minimum system default follows cell-count strap
// - input current upper byte resets to 0x41
// - input current adds 50 mA offset
`timescale 1ns/100ps
module csr_setpoint_bank
    import csr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h10
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    input  wire logic          scl_i,
    input  wire logic          sda_i,
    output logic               sda_o,
    output logic               sda_oe,
    input  wire logic [1:0]    cell_count_strap,
    output csr_setpoint_t      setpoint
);

    logic [2:0] scl_sync_q;
    logic [2:0] sda_sync_q;
    logic [1:0] strap_s1_q;
    logic [1:0] strap_s2_q;
    logic [1:0] strap_cnt_q;
    csr_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic       drive_q;
    logic [7:0] rev_lo_q;
    logic [7:0] vin_lo_q;
    logic [7:0] vin_hi_q;
    logic [7:0] sys_lo_q;
    logic [7:0] sys_hi_q;
    logic [7:0] iin_hi_q;

    // edges from the second and third stage only
    wire scl_rise   = scl_sync_q[1] & ~scl_sync_q[2];
    wire scl_fall   = ~scl_sync_q[1] & scl_sync_q[2];
    wire bus_start  = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[2] & ~sda_sync_q[1];
    wire bus_stop   = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[2] & sda_sync_q[1];
    wire sda_in     = sda_sync_q[1];
    wire ack_entry  = scl_fall & (bit_cnt_q == 4'h8);
    wire byte_begin = scl_fall & (bit_cnt_q == 4'h0);
    wire addr_hit   = (shift_q[7:1] == DEV_ADDR);
    wire wr_en      = ack_entry & (state_q == CSR_WR);
    wire rd_load    = byte_begin & (state_q == CSR_RD);
    // load once the second strap flop holds the pin value, not its reset zero
    wire strap_load = (strap_cnt_q == CSR_STRAP_WAIT);

    // candidate values: the written byte, merged with the stored partner byte for the input regulation pair
    wire [7:0]  vin_lo_c = (wr_en && ptr_q == CSR_OFS_VIN_LO) ? shift_q : vin_lo_q;
    wire [7:0]  vin_hi_c = (wr_en && ptr_q == CSR_OFS_VIN_HI) ? shift_q : vin_hi_q;
    wire [7:0]  sys_hi_c = (wr_en && ptr_q == CSR_OFS_SYS_HI) ? shift_q : sys_hi_q;
    wire [7:0]  vin_code_c = {vin_hi_c[CSR_VIN_HI_POS +: CSR_VIN_HI_W],
                              vin_lo_c[CSR_VIN_LO_POS +: CSR_VIN_LO_W]};
    wire [15:0] vin_mv_c = CSR_VIN_OFS_MV + {2'h0, vin_code_c, 6'h00};
    wire [15:0] sys_mv_c = {2'h0, sys_hi_c[CSR_SYS_POS +: CSR_SYS_W], 8'h00};
    wire        vin_ok   = (vin_mv_c >= CSR_VIN_MIN_MV) && (vin_mv_c <= CSR_VIN_MAX_MV);
    wire        sys_ok   = (sys_mv_c >= CSR_SYS_MIN_MV) && (sys_mv_c <= CSR_SYS_MAX_MV);
    wire        wr_vin   = wr_en && (ptr_q == CSR_OFS_VIN_LO || ptr_q == CSR_OFS_VIN_HI);
    wire        wr_sys   = wr_en && (ptr_q == CSR_OFS_SYS_HI);

    wire [7:0] rd_data =
        (ptr_q == CSR_OFS_REV_LO) ? rev_lo_q :
        (ptr_q == CSR_OFS_VIN_LO) ? vin_lo_q :
        (ptr_q == CSR_OFS_VIN_HI) ? vin_hi_q :
        (ptr_q == CSR_OFS_SYS_LO) ? sys_lo_q :
        (ptr_q == CSR_OFS_SYS_HI) ? sys_hi_q :
        (ptr_q == CSR_OFS_IIN_HI) ? iin_hi_q : 8'h00;

    wire [7:0]  vin_code = {vin_hi_q[CSR_VIN_HI_POS +: CSR_VIN_HI_W],
                            vin_lo_q[CSR_VIN_LO_POS +: CSR_VIN_LO_W]};
    wire [15:0] sys_mv   = {2'h0, sys_hi_q[CSR_SYS_POS +: CSR_SYS_W], 8'h00};
    wire [6:0]  iin_code = iin_hi_q[CSR_IIN_POS +: CSR_IIN_W];

    assign setpoint.input_voltage_regulation_target_mv    = CSR_VIN_OFS_MV + {2'h0, vin_code, 6'h00};
    assign setpoint.sysmin_mv    = sys_mv + CSR_SYS_OFS_MV;
    assign setpoint.iin_limit_ma = 16'(iin_code) * CSR_IIN_STEP_MA + CSR_IIN_OFS_MA;
    assign sda_o  = 1'b0;
    assign sda_oe = drive_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_i};
            sda_sync_q <= {sda_sync_q[1:0], sda_i};
            strap_s1_q <= cell_count_strap;
            strap_s2_q <= strap_s1_q;
        end
    end

    // strap is caught once the synchroniser has filled after reset release
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_cnt_q <= 2'h0;
        end else if (strap_cnt_q != CSR_STRAP_WAIT + 2'h1) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
        end
    end

    // serial slave: byte engine with ack slot as count 8
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q   <= CSR_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            ptr_q     <= 8'h00;
            drive_q   <= 1'b0;
        end else if (bus_start) begin
            state_q   <= CSR_ADDR;
            bit_cnt_q <= 4'h0;
            drive_q   <= 1'b0;
        end else if (bus_stop) begin
            state_q   <= CSR_IDLE;
            drive_q   <= 1'b0;
        end else if (state_q != CSR_IDLE && scl_rise) begin
            if (bit_cnt_q == 4'h8) begin
                bit_cnt_q <= 4'h0;
                if (state_q == CSR_RD && sda_in) begin
                    state_q <= CSR_IDLE;
                end
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                if (state_q != CSR_RD) begin
                    shift_q <= {shift_q[6:0], sda_in};
                end
            end
        end else if (ack_entry) begin
            case (state_q)
                CSR_ADDR: begin
                    drive_q <= addr_hit;
                    state_q <= !addr_hit ? CSR_IDLE : (shift_q[0] ? CSR_RD : CSR_PTR);
                end
                CSR_PTR: begin
                    drive_q <= 1'b1;
                    ptr_q   <= shift_q;
                    state_q <= CSR_WR;
                end
                CSR_WR: begin
                    drive_q <= 1'b1;
                    ptr_q   <= ptr_q + 8'h01;
                end
                default: begin
                    drive_q <= 1'b0;
                end
            endcase
        end else if (rd_load) begin
            shift_q <= rd_data;
            ptr_q   <= ptr_q + 8'h01;
            drive_q <= ~rd_data[7];
        end else if (byte_begin) begin
            drive_q <= 1'b0;
        end else if (scl_fall && state_q == CSR_RD) begin
            shift_q <= {shift_q[6:0], 1'b0};
            drive_q <= ~shift_q[6];
        end
    end

    // setpoint storage; reserved bits are stored as written
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rev_lo_q <= CSR_RST_REV_LO;
            vin_lo_q <= CSR_RST_VIN_LO;
            vin_hi_q <= CSR_RST_VIN_HI;
            sys_lo_q <= CSR_RST_SYS_LO;
            sys_hi_q <= CSR_RST_SYS_HI;
            iin_hi_q <= CSR_RST_IIN_HI;
        end else begin
            if (wr_en && ptr_q == CSR_OFS_REV_LO) begin
                rev_lo_q <= shift_q;
            end
            if (wr_vin && vin_ok) begin
                vin_lo_q <= vin_lo_c;
                vin_hi_q <= vin_hi_c;
            end
            if (wr_en && ptr_q == CSR_OFS_SYS_LO) begin
                sys_lo_q <= shift_q;
            end
            if (strap_load) begin
                sys_hi_q <= {2'h0, CSR_SYS_DEF_CODES[{strap_s2_q, 3'h0} - {strap_s2_q, 1'b0} +: 6]};
            end else if (wr_sys && sys_ok) begin
                sys_hi_q <= sys_hi_c;
            end
            if (wr_en && ptr_q == CSR_OFS_IIN_HI) begin
                iin_hi_q <= shift_q;
            end
        end
    end

    logic first_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_vin_range: assert property (setpoint.input_voltage_regulation_target_mv >= CSR_VIN_MIN_MV &&
        setpoint.input_voltage_regulation_target_mv <= CSR_VIN_MAX_MV) else $error("input regulation out of range");
    chk_vin_offset: assert property ((vin_code == 8'h00) |->
        setpoint.input_voltage_regulation_target_mv == 16'd3200) else $error("input regulation offset wrong");
    chk_vin_weights: assert property (##1 $changed(vin_code) |->
        setpoint.input_voltage_regulation_target_mv == 16'd3200 + 16'(vin_code) * 16'd64)
        else $error("input regulation weights wrong");
    chk_vin_ignore: assert property ((wr_vin && !vin_ok) |=>
        $stable(vin_lo_q) && $stable(vin_hi_q))
        else $error("bad input regulation write stored");
    chk_sys_ignore: assert property ((wr_sys && !sys_ok && !strap_load) |=>
        $stable(sys_hi_q)) else $error("bad minimum system write stored");
    chk_sys_offset: assert property (setpoint.sysmin_mv ==
        16'(sys_hi_q[5:0]) * 16'd256 + 16'd160) else $error("minimum system offset wrong");
    chk_sys_accept: assert property ((wr_sys && sys_ok && !strap_load) |=>
        sys_hi_q == $past(shift_q) && sys_mv >= 16'd1024)
        else $error("good minimum system write lost");
    chk_strap_load: assert property (strap_load |=> sys_hi_q[5:0] ==
        CSR_SYS_DEF_CODES[6*$past(strap_s2_q) +: 6]) else $error("strap default not loaded");
    chk_iin_reset: assert property (first_q |-> iin_hi_q == 8'h41)
        else $error("input current reset value wrong");
    chk_iin_offset: assert property ((iin_code == 7'h00) |->
        setpoint.iin_limit_ma == 16'd50) else $error("input current offset wrong");
    chk_addr_ack: assert property ((ack_entry && state_q == CSR_ADDR && addr_hit) |=>
        sda_oe [*1] ##1 sda_oe) else $error("address not acknowledged");

    cov_vin_write: cover property (wr_vin && vin_ok);
    cov_sys_refused: cover property (wr_sys && !sys_ok);
    cov_read_byte: cover property (rd_load ##[1:1000] (state_q == CSR_RD && scl_rise && bit_cnt_q == 4'h8));

endmodule : csr_setpoint_bank

//--- verilog/csr_pkg.sv
// constants, field layouts and types shared by the charger setpoint register bank
package csr_pkg;

    // register offsets on the serial bus
    localparam logic [7:0] CSR_OFS_REV_LO   = 8'h08;
    localparam logic [7:0] CSR_OFS_VIN_LO   = 8'h0a;
    localparam logic [7:0] CSR_OFS_VIN_HI   = 8'h0b;
    localparam logic [7:0] CSR_OFS_SYS_LO   = 8'h0c;
    localparam logic [7:0] CSR_OFS_SYS_HI   = 8'h0d;
    localparam logic [7:0] CSR_OFS_IIN_HI   = 8'h0f;

    // reset values
    localparam logic [7:0] CSR_RST_REV_LO   = 8'h00;
    localparam logic [7:0] CSR_RST_VIN_LO   = 8'h00;
    localparam logic [7:0] CSR_RST_VIN_HI   = 8'h00;
    localparam logic [7:0] CSR_RST_SYS_LO   = 8'h00;
    localparam logic [7:0] CSR_RST_SYS_HI   = 8'h00;
    localparam logic [7:0] CSR_RST_IIN_HI   = 8'h41;

    // field positions
    localparam int         CSR_VIN_HI_POS   = 0;
    localparam int         CSR_VIN_HI_W     = 6;
    localparam int         CSR_VIN_LO_POS   = 6;
    localparam int         CSR_VIN_LO_W     = 2;
    localparam int         CSR_SYS_POS      = 0;
    localparam int         CSR_SYS_W        = 6;
    localparam int         CSR_IIN_POS      = 0;
    localparam int         CSR_IIN_W        = 7;

    // scaling, offsets and valid ranges
    localparam logic [15:0] CSR_VIN_OFS_MV  = 16'h0c80;   // 3200 mV
    localparam logic [15:0] CSR_VIN_MIN_MV  = 16'h0c80;   // 3200 mV
    localparam logic [15:0] CSR_VIN_MAX_MV  = 16'h4c40;   // 19520 mV
    localparam logic [15:0] CSR_VIN_STEP_MV = 16'h0040;   // 64 mV
    localparam logic [15:0] CSR_SYS_STEP_MV = 16'h0100;   // 256 mV
    localparam logic [15:0] CSR_SYS_MIN_MV  = 16'h0400;   // 1024 mV
    localparam logic [15:0] CSR_SYS_MAX_MV  = 16'h3f00;   // 16128 mV
    localparam logic [15:0] CSR_SYS_OFS_MV  = 16'h00a0;   // 160 mV
    localparam logic [15:0] CSR_IIN_STEP_MA = 16'h0032;   // 50 mA
    localparam logic [15:0] CSR_IIN_OFS_MA  = 16'h0032;   // 50 mA

    // minimum system voltage default codes per strap value 3..0
    localparam logic [23:0] CSR_SYS_DEF_CODES = {6'h30, 6'h24, 6'h18, 6'h0e};
    localparam logic [1:0]  CSR_STRAP_WAIT    = 2'h2;

    typedef enum logic [2:0] {
        CSR_IDLE = 3'b000,
        CSR_ADDR = 3'b001,
        CSR_PTR  = 3'b010,
        CSR_WR   = 3'b011,
        CSR_RD   = 3'b100
    } csr_state_t;

    typedef struct packed {
        logic [15:0] input_voltage_regulation_target_mv;
        logic [15:0] sysmin_mv;
        logic [15:0] iin_limit_ma;
    } csr_setpoint_t;

endpackage : csr_pkg

//--- testbench/csr_host_model.sv
// two-wire bus host model that drives the setpoint bank pins
`timescale 1ns/100ps
module csr_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h10
) (
    input  wire logic ref_clk,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    logic host_low;
    // open-drain data line with pull-up: low while either party pulls
    assign sda = ~(host_low | sda_oe);
    initial begin
        scl = 1'b1;
        host_low = 1'b0;
    end
    // each bus clock phase lasts five core clock cycles
    task automatic half();
        repeat (5) @(negedge ref_clk);
    endtask : half
    task automatic put_bit(input logic b);
        host_low = ~b;
        half();
        scl = 1'b1;
        half();
        scl = 1'b0;
    endtask : put_bit
    task automatic get_bit(output logic b);
        host_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        b = sda;
        scl = 1'b0;
    endtask : get_bit
    // also serves as repeated start
    task automatic start();
        host_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        host_low = 1'b1;
        half();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        host_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        host_low = 1'b0;
        half();
    endtask : stop
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ack = ~b;
    endtask : put_byte
    // one byte access by register offset; the byte is written whole, reserved bits as given
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        put_byte({DEV_ADDR, 1'b0}, a0);
        put_byte(ptr, a1);
        put_byte(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        put_byte({DEV_ADDR, 1'b0}, a0);
        put_byte(ptr, a1);
        start();
        put_byte({DEV_ADDR, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(1'b1);
        stop();
        ok = a0 & a1 & a2;
    endtask : read_reg
    task automatic probe(input logic [6:0] a, output logic ok);
        start();
        put_byte({a, 1'b0}, ok);
        stop();
    endtask : probe
endmodule : csr_host_model

//--- testbench/csr_setpoint_bank_tb.sv
// self-checking bench for the charger setpoint register bank
`timescale 1ns/100ps
module csr_setpoint_bank_tb;
    import csr_pkg::*;
    localparam logic [6:0] BUS_ADDR = 7'h10;
    logic          ref_clk = 1'b0;
    logic          rst_b = 1'b0;
    logic [1:0]    cell_count_strap = 2'h0;
    logic          scl, sda, sda_o, sda_oe, ok;
    csr_setpoint_t setpoint;
    logic [5:0]    def_code [4] = '{6'h0e, 6'h18, 6'h24, 6'h30};
    int            err_total = 0;
    int            tests_run = 0;
    int            cycles = 0;

    csr_setpoint_bank #(.DEV_ADDR(BUS_ADDR)) csr_setpoint_bank_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .cell_count_strap(cell_count_strap), .setpoint(setpoint));
    csr_host_model #(.DEV_ADDR(BUS_ADDR)) csr_host_model_inst (
        .ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic rchk(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] d;
        csr_host_model_inst.read_reg(ptr, d, ok);
        check("read ack", 16'h0001, {15'h0, ok});
        check("read data", {8'h00, exp}, {8'h00, d});
    endtask : rchk
    task automatic wreg(input logic [7:0] ptr, input logic [7:0] d);
        csr_host_model_inst.write_reg(ptr, d, ok);
        check("write ack", 16'h0001, {15'h0, ok});
    endtask : wreg
    task automatic do_reset(input logic [1:0] strap);
        @(negedge ref_clk);
        rst_b = 1'b0;
        cell_count_strap = strap;
        repeat (16) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask : do_reset
    task automatic t_reset_values();
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s));
            check("sysmin", 16'(def_code[s]) * 16'd256 + 16'd160, setpoint.sysmin_mv);
            check("input_voltage_regulation_target", 16'd3200, setpoint.input_voltage_regulation_target_mv);
            check("iin", 16'd3300, setpoint.iin_limit_ma);
        end
        rchk(8'h08, 8'h00);
        rchk(8'h0a, 8'h00);
        rchk(8'h0b, 8'h00);
        rchk(8'h0c, 8'h00);
        rchk(8'h0d, 8'h30);
        rchk(8'h0f, 8'h41);
    endtask : t_reset_values
    task automatic t_vin();
        wreg(8'h0b, 8'h3f);
        wreg(8'h0a, 8'hc0);
        check("input_voltage_regulation_target", 16'd19520, setpoint.input_voltage_regulation_target_mv);
        wreg(8'h0a, 8'h40);
        check("input_voltage_regulation_target", 16'd19392, setpoint.input_voltage_regulation_target_mv);
        wreg(8'h0b, 8'h00);
        wreg(8'h0a, 8'h00);
        check("input_voltage_regulation_target", 16'd3200, setpoint.input_voltage_regulation_target_mv);
    endtask : t_vin
    task automatic t_sys();
        wreg(8'h0d, 8'h03);
        rchk(8'h0d, 8'h30);
        check("sysmin", 16'd12448, setpoint.sysmin_mv);
        wreg(8'h0d, 8'h04);
        check("sysmin", 16'd1184, setpoint.sysmin_mv);
        wreg(8'h0d, 8'h3f);
        check("sysmin", 16'd16288, setpoint.sysmin_mv);
    endtask : t_sys
    task automatic t_iin();
        wreg(8'h0f, 8'h7f);
        check("iin", 16'd6400, setpoint.iin_limit_ma);
        wreg(8'h0f, 8'h00);
        check("iin", 16'd50, setpoint.iin_limit_ma);
        rchk(8'h0f, 8'h00);
    endtask : t_iin
    task automatic t_bus();
        wreg(8'h10, 8'h5a);
        rchk(8'h10, 8'h00);
        csr_host_model_inst.probe(BUS_ADDR ^ 7'h01, ok);
        check("foreign ack", 16'h0000, {15'h0, ok});
        check("sda_o", 16'h0000, {15'h0, sda_o});
        rchk(8'h0d, 8'h3f);
    endtask : t_bus

    initial begin
        t_reset_values();
        t_vin();
        t_sys();
        t_iin();
        t_bus();
        end_of_test();
    end
endmodule : csr_setpoint_bank_tb
